// *** laser_ctl_pkg.sv ***
// Constants, register map and carrier types for the laser DAC control sequencer
package laser_ctl_pkg;
   // Clock rate and timing figures
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_PER_MS = CLK_HZ / 1000;
   localparam int POR_MS = 50;
   localparam int POR_CYCLES = POR_MS * CLK_PER_MS;
   // Hot-plug delay and conversion period have no printed figure
   localparam int HOT_PLUG_MS = 200;
   localparam int HOT_PLUG_CYCLES = HOT_PLUG_MS * CLK_PER_MS;
   localparam int CONV_MS = 100;
   localparam int CONV_CYCLES = CONV_MS * CLK_PER_MS;
   // Register offsets (byte addresses on the serial register space)
   localparam logic [7:0] OFS_TXP_HI = 8'h66;
   localparam logic [7:0] OFS_TXP_LO = 8'h67;
   localparam logic [7:0] OFS_CFG0 = 8'h70;
   localparam logic [7:0] OFS_CFG1 = 8'h71;
   localparam logic [7:0] OFS_CAL0 = 8'h72;
   localparam logic [7:0] OFS_CFG3 = 8'h73;
   localparam logic [7:0] OFS_RXDIV = 8'h74;
   localparam logic [7:0] OFS_SETPT0 = 8'h75;
   localparam logic [7:0] OFS_SETPT1 = 8'h76;
   localparam logic [7:0] OFS_BIAS = 8'h77;
   localparam logic [7:0] OFS_MOD_SETPOINT = 8'h78;
   localparam logic [7:0] OFS_MOD = 8'h79;
   localparam logic [7:0] OFS_READBACK = 8'h7A;
   localparam logic [7:0] OFS_CTRL = 8'h7B;
   // Field positions
   localparam int B_MOD_SWING_REFERENCE = 0;
   localparam int B_SAFETY_SWITCH_POLARITY = 0;
   localparam int B_BPOL = 1;
   localparam int B_OE = 2;
   localparam int B_BYPASS = 0;
   localparam int B_RES_LO = 1;
   localparam int B_INV = 4;
   localparam int B_LPOL = 5;
   localparam int B_SETSEL = 6;
   localparam int B_INTCAL = 0;
   localparam int B_EXTFLT = 1;
   localparam int B_SOFTOFF = 0;
   localparam int B_DRDY = 1;
   localparam int B_PORDONE = 2;
   localparam int B_TXFLT = 3;
   localparam int RXDIV_W = 5;
   // Values after reset
   localparam logic [7:0] RST_CAL0 = 8'h03;
   localparam logic [7:0] RST_CFG1 = 8'h00;
   localparam logic [7:0] RST_CFG3 = 8'h01;
   localparam logic [2:0] RES_MIN = 3'h1;
   // Power-on phases
   typedef enum logic [1:0] {ST_POR, ST_INIT, ST_RUN} phase_type;
   // Analog output drive: hi-Z enable, shutdown flag, shutdown rail, DAC code
   typedef struct packed {
      logic oe_n;
      logic shutdown;
      logic rail_high;
      logic [7:0] code;
   } drive_type;
   // One byte access from the serial interface
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;
   // Saturating add of a signed table offset to an unsigned setpoint
   function automatic logic [7:0] add_sat(input logic [7:0] base, input logic [7:0] off);
      logic [9:0] s;
      s = {2'b00, base} + {{2{off[7]}}, off};
      // Clamp rather than wrap, so a large offset never flips the drive
      if (s[9]) begin
         return 8'h00;
      end else if (s[8]) begin
         return 8'hFF;
      end
      return s[7:0];
   endfunction : add_sat
endpackage : laser_ctl_pkg

// *** laser_dac_control_sequencer.sv ***
// Bias and modulation DAC sequencer with its configuration registers
`timescale 1ns/1ns
// Functional notes
// - TX power at 0x66, width by calibration
// - Receive divider set by five-bit field
// - Divider steps from unity in 1/32
// - Code zero bypasses and disconnects divider
// - Field selects one of seven resistors
// - Bypass bit 0 runs loop; default off
// - Loop on: setpoint plus table to bias
// - Loop off: bias from direct register
// - Applied bias code is readable back
// - Bits set bias response and rail
// - Loop on: modulation setpoint plus table
// - Loop off: modulation from direct register
// - Reference bit sets swing and rail
// - 50 ms init before access or conversions
// - First result one period after init
// - Output enable defaults zero, outputs float
// - Safety switch shutdown level by enable, polarity
// - Bias shutdown level by enable, bias polarity
// - Laser off until hot-plug delay passes
// - Loop starts only with output enable
// - Transmit disable keeps laser off, conversions run
// - Safety switch active whenever laser off; code floats it with enable clear or external fault mode
// - Fault shuts laser, asserts transmit fault
module laser_dac_control_sequencer #(
   parameter int POR_CYC = laser_ctl_pkg::POR_CYCLES,
   parameter int HOT_PLUG_CYC = laser_ctl_pkg::HOT_PLUG_CYCLES,
   parameter int CONV_CYC = laser_ctl_pkg::CONV_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire laser_ctl_pkg::reg_req_type req,
   output logic [7:0] reg_rdata,
   input wire logic tx_disable,
   input wire logic fault_detect,
   input wire logic ext_fault_in,
   input wire logic signed [7:0] bias_temp_table,
   input wire logic signed [7:0] mod_temp_table,
   input wire logic [15:0] tx_power_adc,
   output laser_ctl_pkg::drive_type bias_drive_output,
   output laser_ctl_pkg::drive_type mod_drive_output,
   output logic safety_switch_drive,
   output logic safety_switch_oe_n,
   output logic tx_fault,
   output logic conv_done,
   output logic [4:0] rx_gain_divider,
   output logic rx_divider_connect,
   output logic [2:0] feedback_res_sel,
   output logic feedback_invert
);
   import laser_ctl_pkg::*;
   // Configuration and status registers
   logic [7:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d, cal0_q, cal0_d, cfg3_q, cfg3_d;
   logic [4:0] rxdiv_q, rxdiv_d;
   logic rxconn_q, rxconn_d; // Divider network attached to the receive input
   logic [7:0] setpt0_q, setpt0_d, setpt1_q, setpt1_d;
   logic [7:0] bias_q, bias_d, mod_setpoint_q, mod_setpoint_d, mod_q, mod_d;
   logic soft_off_q, soft_off_d, drdy_q, drdy_d, fault_q, fault_d;
   logic [15:0] txp_q, txp_d;
   logic [7:0] rdata_q, rdata_d;
   // Sequencing state
   phase_type phase_q, phase_d;
   logic [31:0] cnt_q, cnt_d;      // Power-on and hot-plug timer
   logic [31:0] conv_q, conv_d;    // Conversion period timer
   logic conv_done_q, conv_done_d;
   // Registered outputs
   drive_type bias_out_q, bias_out_d;
   drive_type mod_out_q, mod_out_d;
   logic sw_q, sw_d;
   logic sw_oe_n_q, sw_oe_n_d;
   logic txf_q, txf_d;
   logic [7:0] readback_q, readback_d;
   // Combinational helpers; the laser flag gates every drive
   logic access_ok, laser_on, loop_on;
   logic [7:0] bias_code, mod_code;
   // Access only after the power-on interval ends
   assign access_ok = (phase_q != ST_POR);
   // Loop runs with bypass clear and output enable set
   assign loop_on = !cal0_q[B_BYPASS] && cfg1_q[B_OE];
   // Laser only after hot-plug delay, not disabled, no fault
   assign laser_on = (phase_q == ST_RUN) && cfg1_q[B_OE] && !tx_disable && !soft_off_q
      && !fault_q && !fault_detect;
   // Register file, timers and phase: next values
   always_comb begin
      cfg0_d = cfg0_q;
      cfg1_d = cfg1_q;
      cal0_d = cal0_q;
      cfg3_d = cfg3_q;
      rxdiv_d = rxdiv_q;
      setpt0_d = setpt0_q;
      setpt1_d = setpt1_q;
      bias_d = bias_q;
      mod_setpoint_d = mod_setpoint_q;
      mod_d = mod_q;
      soft_off_d = soft_off_q;
      drdy_d = drdy_q;
      fault_d = fault_q;
      txp_d = txp_q;
      rdata_d = 8'h00;
      phase_d = phase_q;
      cnt_d = cnt_q;
      conv_d = conv_q;
      conv_done_d = 1'b0;
      // Writes are dropped during the power-on interval
      if (req.wr && access_ok) begin
         unique case (req.addr)
            OFS_CFG0: cfg0_d = req.wdata;
            OFS_CFG1: cfg1_d = req.wdata;
            OFS_CAL0: begin
               cal0_d = req.wdata;
               // Code zero is not a resistor; keep one of seven valid
               if (req.wdata[B_RES_LO+:3] == 3'h0) begin
                  cal0_d[B_RES_LO+:3] = RES_MIN;
               end
            end
            OFS_CFG3: cfg3_d = req.wdata;
            OFS_RXDIV: rxdiv_d = req.wdata[RXDIV_W-1:0];
            OFS_SETPT0: setpt0_d = req.wdata;
            OFS_SETPT1: setpt1_d = req.wdata;
            OFS_BIAS: bias_d = req.wdata;
            OFS_MOD_SETPOINT: mod_setpoint_d = req.wdata;
            OFS_MOD: mod_d = req.wdata;
            OFS_CTRL: soft_off_d = req.wdata[B_SOFTOFF];
            default: ;
         endcase
      end
      // Reads answer one cycle later; unmapped addresses read zero
      if (req.rd && access_ok) begin
         unique case (req.addr)
            OFS_TXP_HI: rdata_d = txp_q[15:8];
            // External calibration holds one byte only
            OFS_TXP_LO: rdata_d = cfg3_q[B_INTCAL] ? txp_q[7:0] : 8'h00;
            OFS_CFG0: rdata_d = cfg0_q;
            OFS_CFG1: rdata_d = cfg1_q;
            OFS_CAL0: rdata_d = cal0_q;
            OFS_CFG3: rdata_d = cfg3_q;
            OFS_RXDIV: rdata_d = {3'h0, rxdiv_q};
            OFS_SETPT0: rdata_d = setpt0_q;
            OFS_SETPT1: rdata_d = setpt1_q;
            OFS_BIAS: rdata_d = bias_q;
            OFS_MOD_SETPOINT: rdata_d = mod_setpoint_q;
            OFS_MOD: rdata_d = mod_q;
            OFS_READBACK: rdata_d = readback_q;
            OFS_CTRL: rdata_d = {4'h0, txf_q, 1'b1, drdy_q, soft_off_q};
            default: rdata_d = 8'h00;
         endcase
         // Reading control clears data ready
         if (req.addr == OFS_CTRL) begin
            drdy_d = 1'b0;
         end
      end
      // Phase sequencing: POR, then hot-plug wait, then run
      unique case (phase_q)
         ST_POR: begin
            cnt_d = cnt_q + 32'd1;
            if (cnt_q >= 32'(POR_CYC - 1)) begin
               phase_d = ST_INIT;
               cnt_d = 32'd0;
            end
         end
         ST_INIT: begin
            cnt_d = cnt_q + 32'd1;
            if (cnt_q >= 32'(HOT_PLUG_CYC - 1)) begin
               phase_d = ST_RUN;
            end
         end
         ST_RUN: ;
      endcase
      // Conversions run after POR regardless of transmit disable
      if (access_ok) begin
         conv_d = conv_q + 32'd1;
         if (conv_q >= 32'(CONV_CYC - 1)) begin
            conv_d = 32'd0;
            conv_done_d = 1'b1;
            txp_d = tx_power_adc;
            // Set wins over a same-cycle clear on read
            drdy_d = 1'b1;
         end
      end
      // Fault latches until transmit disable is asserted
      if (tx_disable) begin
         fault_d = 1'b0;
      end
      if (fault_detect) begin
         fault_d = 1'b1;
      end
      // Code zero leaves the resistor network off the receive input
      rxconn_d = (rxdiv_d != 5'h00);
   end
   // Register file, timers and phase: storage
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg0_q <= 8'h00;
         cfg1_q <= RST_CFG1;
         cal0_q <= RST_CAL0;
         cfg3_q <= RST_CFG3;
         rxdiv_q <= 5'h00;
         setpt0_q <= 8'h00;
         setpt1_q <= 8'h00;
         bias_q <= 8'h00;
         mod_setpoint_q <= 8'h00;
         mod_q <= 8'h00;
         soft_off_q <= 1'b0;
         drdy_q <= 1'b0;
         fault_q <= 1'b0;
         txp_q <= 16'h0000;
         rdata_q <= 8'h00;
         phase_q <= ST_POR;
         cnt_q <= 32'd0;
         conv_q <= 32'd0;
         conv_done_q <= 1'b0;
         rxconn_q <= 1'b0;
      end else begin
         cfg0_q <= cfg0_d;
         cfg1_q <= cfg1_d;
         cal0_q <= cal0_d;
         cfg3_q <= cfg3_d;
         rxdiv_q <= rxdiv_d;
         setpt0_q <= setpt0_d;
         setpt1_q <= setpt1_d;
         bias_q <= bias_d;
         mod_setpoint_q <= mod_setpoint_d;
         mod_q <= mod_d;
         soft_off_q <= soft_off_d;
         drdy_q <= drdy_d;
         fault_q <= fault_d;
         txp_q <= txp_d;
         rdata_q <= rdata_d;
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         conv_q <= conv_d;
         conv_done_q <= conv_done_d;
         rxconn_q <= rxconn_d;
      end
   end
   // DAC codes: loop adds table offsets, bypass uses direct registers
   always_comb begin
      bias_code = loop_on ? add_sat(cal0_q[B_SETSEL] ? setpt1_q : setpt0_q,
         bias_temp_table) : bias_q;
      // Inverted response flips the numeric sense of the bias DAC
      if (cal0_q[B_LPOL]) begin
         bias_code = ~bias_code;
      end
      mod_code = loop_on ? add_sat(mod_setpoint_q, mod_temp_table) : mod_q;
      // Swing down from supply uses the complement code
      if (cfg0_q[B_MOD_SWING_REFERENCE]) begin
         mod_code = ~mod_code;
      end
   end
   // Output drive: next values
   always_comb begin
      bias_out_d.oe_n = !cfg1_q[B_OE];
      bias_out_d.shutdown = !laser_on;
      bias_out_d.rail_high = cfg1_q[B_BPOL];
      bias_out_d.code = laser_on ? bias_code : 8'h00;
      mod_out_d.oe_n = !cfg1_q[B_OE];
      mod_out_d.shutdown = !laser_on;
      mod_out_d.rail_high = cfg0_q[B_MOD_SWING_REFERENCE];
      mod_out_d.code = laser_on ? mod_code : 8'h00;
      readback_d = bias_out_d.code;
      // Pin becomes a fault input when external fault mode is chosen
      sw_oe_n_d = !cfg1_q[B_OE] || cfg3_q[B_EXTFLT];
      sw_d = laser_on ? !cfg1_q[B_SAFETY_SWITCH_POLARITY] : cfg1_q[B_SAFETY_SWITCH_POLARITY];
      txf_d = fault_q || fault_detect || (cfg3_q[B_EXTFLT] && ext_fault_in);
   end
   // Output drive: storage
   always_ff @(posedge clk) begin
      if (srst) begin
         bias_out_q <= '{oe_n: 1'b1, shutdown: 1'b1, rail_high: 1'b0, code: 8'h00};
         mod_out_q <= '{oe_n: 1'b1, shutdown: 1'b1, rail_high: 1'b0, code: 8'h00};
         readback_q <= 8'h00;
         sw_q <= 1'b0;
         sw_oe_n_q <= 1'b1;
         txf_q <= 1'b0;
      end else begin
         bias_out_q <= bias_out_d;
         mod_out_q <= mod_out_d;
         readback_q <= readback_d;
         sw_q <= sw_d;
         sw_oe_n_q <= sw_oe_n_d;
         txf_q <= txf_d;
      end
   end
   assign reg_rdata = rdata_q;
   assign bias_drive_output = bias_out_q;
   assign mod_drive_output = mod_out_q;
   assign safety_switch_drive = sw_q;
   assign safety_switch_oe_n = sw_oe_n_q;
   assign tx_fault = txf_q;
   assign conv_done = conv_done_q;
   // Divider ratio (32-code)/32; zero leaves the input unloaded
   assign rx_gain_divider = rxdiv_q;
   assign rx_divider_connect = rxconn_q;
   assign feedback_res_sel = cal0_q[B_RES_LO+:3];
   assign feedback_invert = cal0_q[B_INV];
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_fault_seen;
      fault_detect;
   endsequence
   sequence s_shut_both;
      bias_out_q.shutdown && mod_out_q.shutdown && txf_q;
   endsequence
   chk_por_no_write: assert property ((phase_q == ST_POR) && req.wr |=> $stable(cal0_q))
      else $error("register changed during power-on interval");
   chk_conv_ready: assert property ($rose(drdy_q) |->
      $past(conv_q) == 32'(CONV_CYC - 1))
      else $error("data ready outside conversion end");
   chk_readback_match: assert property (readback_q == bias_out_q.code)
      else $error("readback differs from applied bias code");
   chk_oe_float: assert property (!cfg1_q[B_OE] |=> bias_out_q.oe_n && mod_out_q.oe_n
      && sw_oe_n_q)
      else $error("output driven with enable clear");
   chk_switch_level: assert property (cfg1_q[B_OE] && !laser_on |=>
      sw_q == $past(cfg1_q[B_SAFETY_SWITCH_POLARITY]))
      else $error("safety switch shutdown level wrong");
   chk_bias_rail: assert property (bias_out_q.rail_high == $past(cfg1_q[B_BPOL]))
      else $error("bias shutdown rail wrong");
   chk_fault_shut: assert property (s_fault_seen |=> s_shut_both)
      else $error("fault did not shut laser down");
   chk_txdis_off: assert property (tx_disable |=>
      bias_out_q.shutdown && mod_out_q.shutdown)
      else $error("laser on while transmit disabled");
   chk_hotplug_wait: assert property ((phase_q != ST_RUN) |=> bias_out_q.shutdown)
      else $error("laser on before hot-plug delay");
   chk_div_bypass: assert property (rx_divider_connect == (rxdiv_q != 5'h00))
      else $error("divider connection disagrees with code");
   chk_direct_bias: assert property (laser_on && cal0_q[B_BYPASS] && !cal0_q[B_LPOL]
      |=> bias_out_q.code == $past(bias_q))
      else $error("direct bias not applied");
   chk_mod_sum: assert property (laser_on && loop_on && !cfg0_q[B_MOD_SWING_REFERENCE]
      |=> mod_out_q.code == add_sat($past(mod_setpoint_q), $past(mod_temp_table)))
      else $error("modulation sum not applied");
endmodule : laser_dac_control_sequencer

// *** laser_link_model.sv ***
// Behavioural laser driver and transmit power monitor on the sequencer's far side
`timescale 1ns/1ns
module laser_link_model
   import laser_ctl_pkg::*;
(
   input wire logic clk,
   input wire laser_ctl_pkg::drive_type bias_drive_output,
   input wire laser_ctl_pkg::drive_type mod_drive_output,
   output logic laser_on,
   output logic [15:0] tx_power_adc
);
   // Light only when both drives are enabled and out of shutdown
   always_ff @(posedge clk) begin
      laser_on <= !bias_drive_output.oe_n && !bias_drive_output.shutdown &&
                  !mod_drive_output.oe_n && !mod_drive_output.shutdown;
   end
   // Monitor photodiode: a dark laser reads zero, a lit one reads its codes
   always_ff @(posedge clk) begin
      tx_power_adc <= laser_on ? {bias_drive_output.code, mod_drive_output.code} : 16'h0000;
   end
endmodule : laser_link_model

// *** tb_top.sv ***
// Self-checking bench for the laser DAC control sequencer
`timescale 1ns/1ns
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb_top;
   import laser_ctl_pkg::*;
   localparam int POR = 20; // Short power-on interval keeps the run brief
   localparam int HOT = 60; // Hot-plug delay, longer than a conversion
   localparam int CONV = 10;
   logic clk, srst, tx_disable, fault_detect, ext_fault_in;
   reg_req_type req;
   logic [7:0] reg_rdata, v;
   logic signed [7:0] bias_tab, mod_tab;
   logic [15:0] txp;
   drive_type bias_drv, mod_drv;
   logic sw_drv, sw_oe_n, tx_fault, conv_done, laser_on, rx_conn, fb_inv;
   logic [4:0] rxdiv;
   logic [2:0] res_sel;
   int bad_count, comparisons, cyc, first_conv, conv_cnt, total;
   laser_dac_control_sequencer #(.POR_CYC(POR), .HOT_PLUG_CYC(HOT), .CONV_CYC(CONV)) uut (
      .clk(clk), .srst(srst), .req(req), .reg_rdata(reg_rdata), .tx_disable(tx_disable),
      .fault_detect(fault_detect), .ext_fault_in(ext_fault_in), .bias_temp_table(bias_tab),
      .mod_temp_table(mod_tab), .tx_power_adc(txp), .bias_drive_output(bias_drv),
      .mod_drive_output(mod_drv), .safety_switch_drive(sw_drv), .safety_switch_oe_n(sw_oe_n),
      .tx_fault(tx_fault), .conv_done(conv_done), .rx_gain_divider(rxdiv),
      .rx_divider_connect(rx_conn), .feedback_res_sel(res_sel), .feedback_invert(fb_inv));
   laser_link_model link (.clk(clk), .bias_drive_output(bias_drv), .mod_drive_output(mod_drv),
      .laser_on(laser_on), .tx_power_adc(txp));
   // Free-running clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Cycle bookkeeping since reset release, first conversion and hang guard
   always @(posedge clk) begin
      total <= total + 1;
      cyc <= srst ? 0 : cyc + 1;
      conv_cnt <= srst ? 0 : conv_cnt + int'(conv_done);
      if (conv_done && first_conv == 0) begin
         first_conv <= cyc;
      end
      if (total == 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   // Compare with case equality so unknowns never match
   task automatic check(string n, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", n, e, g);
      end
   endtask : check
   // Inputs move 1 ns after the rising edge
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wait_cyc(int n);
      while (cyc < n) tick(1);
   endtask : wait_cyc
   // Register write: strobe held over one edge, then a quiet cycle
   task automatic wr(logic [7:0] a, logic [7:0] d);
      req.addr = a;
      req.wdata = d;
      req.wr = 1'b1;
      tick(1);
      req.wr = 1'b0;
      tick(1);
   endtask : wr
   // Register read: data is registered at the strobe's edge
   task automatic rdv(logic [7:0] a, output logic [7:0] d);
      req.addr = a;
      req.rd = 1'b1;
      tick(1);
      req.rd = 1'b0;
      d = reg_rdata;
      tick(1);
   endtask : rdv
   task automatic rd(logic [7:0] a, logic [7:0] e, string n);
      logic [7:0] d;
      rdv(a, d);
      `CHK(n, e, d);
   endtask : rd
   task automatic t_por();
      `CHK("por_oe_n", 3'b111, {bias_drv.oe_n, mod_drv.oe_n, sw_oe_n});
      wr(OFS_CFG1, 8'h07);
      rd(OFS_CFG1, 8'h00, "por_read");
      wait_cyc(POR + 2);
      rdv(OFS_CTRL, v);
      `CHK("por_done", 1'b1, v[B_PORDONE]);
      rd(OFS_CAL0, RST_CAL0, "cal0_rst");
      rd(OFS_CFG1, RST_CFG1, "cfg1_rst");
      rd(OFS_CFG3, RST_CFG3, "cfg3_rst");
      $display("test por done");
   endtask : t_por
   task automatic t_shutdown_levels();
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CFG1, (i == 2) ? 8'h03 : {5'h00, 1'b1, i[0], i[0]});
         wr(OFS_CFG0, {7'h00, i[0]});
         tick(2);
         `CHK("bias_oe_n", i == 2, bias_drv.oe_n);
         `CHK("sw_oe_n", i == 2, sw_oe_n);
         `CHK("mod_oe_n", i == 2, mod_drv.oe_n);
         `CHK("init_off", 1'b1, bias_drv.shutdown && !laser_on);
         if (i < 2) begin
            `CHK("bias_rail", i[0], bias_drv.rail_high);
            `CHK("mod_rail", i[0], mod_drv.rail_high);
            `CHK("sw_level", i[0], sw_drv);
         end
      end
      wr(OFS_CFG1, 8'h04);
      $display("test shutdown levels done");
   endtask : t_shutdown_levels
   task automatic t_direct();
      wait_cyc(POR + HOT + 3);
      wr(OFS_BIAS, 8'h5A);
      wr(OFS_MOD, 8'h33);
      tick(2);
      `CHK("bias_code", 8'h5A, bias_drv.code);
      `CHK("mod_code", 8'h33, mod_drv.code);
      `CHK("sw_on", 1'b1, sw_drv);
      rd(OFS_READBACK, 8'h5A, "readback");
      for (int i = 0; i < 30 && !conv_done; i++) tick(1);
      tick(2);
      rd(OFS_TXP_HI, 8'h5A, "txp_hi");
      rd(OFS_TXP_LO, 8'h33, "txp_lo");
      wr(OFS_CFG3, 8'h00);
      rd(OFS_TXP_HI, 8'h5A, "txp_ext_hi");
      rd(OFS_TXP_LO, 8'h00, "txp_ext_lo");
      wr(OFS_CFG3, RST_CFG3);
      // First result lands one conversion period after power-on ends
      `CHK("first_conv", POR + CONV, first_conv);
      $display("test direct done");
   endtask : t_direct
   task automatic t_loop();
      bias_tab = -8'sd5;
      mod_tab = 8'sd3;
      wr(OFS_SETPT0, 8'h40);
      wr(OFS_SETPT1, 8'h10);
      wr(OFS_MOD_SETPOINT, 8'h20);
      wr(OFS_CAL0, 8'h02);
      tick(2);
      `CHK("loop_bias", 8'h3B, bias_drv.code);
      `CHK("loop_mod", 8'h23, mod_drv.code);
      rd(OFS_READBACK, 8'h3B, "loop_readback");
      wr(OFS_CAL0, 8'h42);
      tick(2);
      `CHK("setpt1", 8'h0B, bias_drv.code);
      wr(OFS_CAL0, 8'h22);
      wr(OFS_CFG0, 8'h01);
      tick(2);
      `CHK("bias_inv", 8'hC4, bias_drv.code);
      `CHK("mod_ref", 8'hDC, mod_drv.code);
      wr(OFS_CFG0, 8'h00);
      $display("test loop done");
   endtask : t_loop
   task automatic t_analog();
      wr(OFS_RXDIV, 8'h00);
      `CHK("rx_bypass", 1'b0, rx_conn);
      wr(OFS_RXDIV, 8'h1F);
      `CHK("rx_div", 6'h3F, {rx_conn, rxdiv});
      wr(OFS_RXDIV, 8'h01);
      `CHK("rx_step", 6'h21, {rx_conn, rxdiv});
      wr(OFS_CAL0, 8'h01);
      `CHK("res_zero", RES_MIN, res_sel);
      wr(OFS_CAL0, 8'h1F);
      `CHK("res_max", 4'hF, {fb_inv, res_sel});
      $display("test analog done");
   endtask : t_analog
   task automatic t_off();
      wr(OFS_CAL0, 8'h03);
      wr(OFS_CFG1, 8'h05);
      wr(OFS_CTRL, 8'h01);
      tick(1);
      `CHK("soft_off", 10'h201, {bias_drv.shutdown, bias_drv.code, sw_drv});
      wr(OFS_CTRL, 8'h00);
      tick(1);
      `CHK("soft_on", 2'b00, {bias_drv.shutdown, sw_drv});
      tx_disable = 1'b1;
      tick(2);
      `CHK("txdis_off", 2'b11, {bias_drv.shutdown, sw_drv});
      tx_disable = 1'b0;
      tick(2);
      fault_detect = 1'b1;
      tick(1);
      `CHK("fault", 4'hF, {tx_fault, bias_drv.shutdown, mod_drv.shutdown, sw_drv});
      fault_detect = 1'b0;
      tick(2);
      `CHK("fault_held", 1'b1, tx_fault);
      tx_disable = 1'b1;
      tick(2);
      tx_disable = 1'b0;
      tick(2);
      `CHK("fault_clr", 1'b0, tx_fault);
      // External fault mode: switch pin floats as an input, input feeds the fault
      wr(OFS_CFG3, 8'h03);
      ext_fault_in = 1'b1;
      tick(2);
      `CHK("ext_fault", 2'b11, {tx_fault, sw_oe_n});
      ext_fault_in = 1'b0;
      wr(OFS_CFG3, RST_CFG3);
      `CHK("ext_clr", 2'b00, {tx_fault, sw_oe_n});
      $display("test off done");
   endtask : t_off
   task automatic t_txdis_powerup();
      tx_disable = 1'b1;
      srst = 1'b1;
      tick(2);
      srst = 1'b0;
      wait_cyc(POR + 2);
      wr(OFS_CFG1, 8'h04);
      wr(OFS_BIAS, 8'h5A);
      wait_cyc(POR + HOT + 5);
      `CHK("pwrup_off", 3'b110, {bias_drv.shutdown, mod_drv.shutdown, laser_on});
      `CHK("pwrup_conv", 1'b1, conv_cnt >= 1);
      $display("test txdis powerup done");
   endtask : t_txdis_powerup
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // Main sequence: reset, then each scenario in turn
   initial begin
      srst = 1'b1;
      req = '0;
      tx_disable = 1'b0;
      fault_detect = 1'b0;
      ext_fault_in = 1'b0;
      bias_tab = 8'sd0;
      mod_tab = 8'sd0;
      bad_count = 0;
      comparisons = 0;
      total = 0;
      first_conv = 0;
      tick(4);
      srst = 1'b0;
      tick(1);
      t_por();
      t_shutdown_levels();
      t_direct();
      t_loop();
      t_analog();
      t_off();
      t_txdis_powerup();
      tally_and_finish();
   end
endmodule : tb_top
